/* verilog/rtcs_rtc.sv */
`timescale 1ns/1ns
`default_nettype none
// serial link: runs on the host's clock, held in reset while deselected
module rtcs_spi_link import rtcs_pkg::*; (
  // link pins
  input  wire logic       sck,
  input  wire logic       csN,
  input  wire logic       sdi,
  output var  logic       sdo,
  output var  logic       sdoOe,
  // core handshakes
  input  wire logic       ackToggle,
  input  wire logic [7:0] rdData,
  output var  logic       wrToggle,
  output var  rtcs_xfer_t wrHold,
  output var  logic       rdToggle,
  output var  logic [6:0] rdAddr
);
  rtcs_link_t l, n;
  logic [7:0] shIn;

  always_comb begin
    n = l;
    shIn = {l.shift[6:0], sdi};
    n.sdoOe = 1'b1;
    n.ackSync = {l.ackSync[0], ackToggle};
    n.shift = shIn;
    n.bitCnt = l.bitCnt + 3'h1;
    n.sdoSh = {l.sdoSh[6:0], 1'b0};
    if (l.bitCnt == 3'h7) begin
      if (!l.started) begin
        n.started = 1'b1;
        n.isWrite = shIn[7];
        n.addr = shIn[6:0];
        if (!shIn[7]) begin
          // reads lag one byte so the core has a byte time to answer
          n.rAddr = shIn[6:0];
          n.rTog = ~l.rTog;
          n.addr = shIn[6:0] + 7'h01;
          n.sdoSh = 8'h00;
        end
      end else if (l.isWrite) begin
        n.wHold = '{addr: l.addr, data: shIn};
        n.wTog = ~l.wTog;
        n.addr = l.addr + 7'h01;
      end else begin
        n.sdoSh = (l.ackSync[1] == l.rTog) ? rdData : RD_NOT_READY;
        n.rAddr = l.addr;
        n.rTog = ~l.rTog;
        n.addr = l.addr + 7'h01;
      end
    end
  end

  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      l <= '0;
    end else begin
      l <= n;
    end
  end

  assign sdo      = l.sdoSh[7];
  assign sdoOe    = l.sdoOe;
  assign wrToggle = l.wTog;
  assign wrHold   = l.wHold;
  assign rdToggle = l.rTog;
  assign rdAddr   = l.rAddr;
endmodule

module rtcs_rtc import rtcs_pkg::*; #(
  parameter int RC_DIV       = 3052,
  parameter int CAL_WINDOW_S = 8
) (
  // system
  input  wire logic clk,
  input  wire logic rst,
  // serial register port
  input  wire logic sck,
  input  wire logic csN,
  input  wire logic sdi,
  output var  logic sdo,
  output var  logic sdoOe,
  // timebase, supply and reset request input
  input  wire logic crystalInputPin,
  input  wire logic mainPowerGood,
  input  wire logic extResetInN,
  // device pins
  output var  logic primaryIrqPin,
  output var  logic secondaryPin,
  output var  logic timerIrqPin,
  output var  logic waveTogglePin,
  output var  logic squareWavePin,
  output var  logic resetRequestPin
);
  localparam logic [15:0] RC_LAST = 16'(RC_DIV - 1);
  localparam logic [9:0] CAL_WIN_LAST = 10'(CAL_WINDOW_S - 1);
  localparam logic [9:0] CAL_PER_LAST = 10'(CAL_PERIOD_S - 1);
  localparam logic [23:0] CAL_EXPECT = 24'(XTAL_HZ * CAL_WINDOW_S);

  rtcs_core_t s, n;
  logic       linkWrTog, linkRdTog;
  rtcs_xfer_t linkWr;
  logic [6:0] linkRdAddr;
  logic       xtalRise, rcTick, srcTick, secTick, xSecTick, tmrTick;
  logic       wrFire, dayCarry, carry, wave, calStart;
  logic [23:0] trimCalc;

  rtcs_spi_link u_link (
    .sck       (sck),
    .csN       (csN),
    .sdi       (sdi),
    .sdo       (sdo),
    .sdoOe     (sdoOe),
    .ackToggle (s.rAck),
    .rdData    (s.rdHold),
    .wrToggle  (linkWrTog),
    .wrHold    (linkWr),
    .rdToggle  (linkRdTog),
    .rdAddr    (linkRdAddr)
  );

  function automatic logic [7:0] calMax(input int i);
    case (i)
      3:       calMax = 8'd23;
      4:       calMax = 8'd31;
      5:       calMax = 8'd12;
      6:       calMax = 8'd99;
      default: calMax = 8'd59;
    endcase
  endfunction

  function automatic logic [7:0] regRead(input logic [6:0] a,
                                         input rtcs_core_t c);
    case (a)
      OFF_CAL_FRACTION:    regRead = c.presc[14:7];
      OFF_CONTROL_ONE:     regRead = c.ctrl1;
      OFF_CONTROL_TWO:     regRead = c.ctrl2;
      OFF_INTERRUPT_MASK:  regRead = c.imask;
      OFF_SQUARE_WAVE:     regRead = c.square_wave_control;
      OFF_RC_TRIM_LOW:     regRead = c.trimLo;
      OFF_RC_TRIM_HIGH:    regRead = c.trimHi;
      OFF_COUNTDOWN_CTL:   regRead = c.tmrCtl;
      OFF_COUNTDOWN_VALUE: regRead = c.tmrVal;
      OFF_OSC_CONTROL:     regRead = c.osc;
      default: begin
        // the key register is write-only and reads as zero
        if (a > OFF_CAL_FRACTION && a <= OFF_CAL_LAST) begin
          regRead = c.cal[a[2:0]];
        end else begin
          regRead = 8'h00;
        end
      end
    endcase
  endfunction

  always_comb begin
    n = s;
    // two-flop synchronisers, three for the write toggle; stage 2 of crystal sync doubles as history
    n.xtalSync   = {s.xtalSync[1:0], crystalInputPin};
    n.extRstSync = {s.extRstSync[0], extResetInN};
    n.pwrSync    = {s.pwrSync[0], mainPowerGood};
    n.csSync     = {s.csSync[0], csN};
    n.wSync      = {s.wSync[1:0], linkWrTog};
    n.rSync      = {s.rSync[0], linkRdTog};
    xtalRise = s.xtalSync[1] & ~s.xtalSync[2];
    rcTick   = (s.rcDiv == RC_LAST);
    n.rcDiv  = rcTick ? 16'h0000 : s.rcDiv + 16'h0001;
    srcTick  = s.osc[OSC_SOURCE] ? rcTick : xtalRise;
    secTick  = srcTick && (s.presc == 15'h7FFF);
    if (srcTick) begin
      n.presc = s.presc + 15'h0001;
    end
    // crystal-only second count, the reference for calibration
    xSecTick = xtalRise && (s.xPresc == 15'h7FFF);
    if (xtalRise) begin
      n.xPresc = s.xPresc + 15'h0001;
    end

    // calendar ripple; timekeeping ignores main power state
    dayCarry = secTick && s.cal[1] == 8'd59 && s.cal[2] == 8'd59 &&
               s.cal[3] == 8'd23;
    carry = secTick;
    for (int i = 1; i < 7; i++) begin
      if (carry) begin
        if (s.cal[i] >= calMax(i)) begin
          n.cal[i] = (i == 4 || i == 5) ? 8'h01 : 8'h00;
        end else begin
          n.cal[i] = s.cal[i] + 8'h01;
          carry = 1'b0;
        end
      end
    end
    if (dayCarry) begin
      n.cal[7] = (s.cal[7] >= 8'd6) ? 8'h00 : s.cal[7] + 8'h01;
    end

    // countdown timer
    case (s.tmrCtl[TMR_FREQ_LSB +: 2])
      2'h0:    tmrTick = srcTick && s.presc[2:0] == 3'h7;
      2'h1:    tmrTick = srcTick && s.presc[8:0] == 9'h1FF;
      2'h2:    tmrTick = secTick;
      default: tmrTick = secTick && s.cal[1] == 8'd59;
    endcase
    if (s.tmrCtl[TMR_RUN] && tmrTick && s.tmrVal != 8'h00) begin
      n.tmrVal = s.tmrVal - 8'h01;
    end

    // autocalibration: measure RC ticks against crystal seconds
    trimCalc = CAL_EXPECT - s.rcCount;
    case (s.calSt)
      CAL_MEASURE: begin
        if (rcTick) begin
          n.rcCount = s.rcCount + 24'h00_0001;
        end
        if (xSecTick) begin
          n.calSec = s.calSec + 10'h001;
          if (s.calSec == CAL_WIN_LAST) begin
            n.trimLo = trimCalc[7:0];
            n.trimHi = trimCalc[15:8];
            n.calSt = CAL_HOLD;
          end
        end
      end
      CAL_HOLD: begin
        if (xSecTick) begin
          n.calSec = s.calSec + 10'h001;
          if (s.calSec == CAL_PER_LAST) begin
            n.calSec = 10'h000;
            n.rcCount = 24'h00_0000;
            n.calSt = CAL_MEASURE;
          end
        end
      end
      default: begin
        n.calSec = 10'h000;
      end
    endcase
    if (s.osc[OSC_AUTO_CALIBRATION_MODE_LSB +: 2] != AUTO_CALIBRATION_MODE_PERIODIC) begin
      n.calSt = CAL_IDLE;
    end

    // host writes; the link hold word is stable while its toggle is new
    wrFire = !s.csSync[1] && (s.wSync[2] != s.wSeen) && s.pwrSync[1];
    n.wSeen = s.wSync[2];
    calStart = 1'b0;
    if (wrFire) begin
      case (linkWr.addr)
        OFF_CONTROL_ONE:     n.ctrl1 = linkWr.data;
        OFF_CONTROL_TWO:     n.ctrl2 = linkWr.data;
        OFF_INTERRUPT_MASK:  n.imask = linkWr.data;
        OFF_SQUARE_WAVE:     n.square_wave_control = linkWr.data;
        OFF_RC_TRIM_LOW:     n.trimLo = linkWr.data;
        OFF_RC_TRIM_HIGH:    n.trimHi = linkWr.data;
        OFF_COUNTDOWN_CTL:   n.tmrCtl = linkWr.data;
        OFF_COUNTDOWN_VALUE: n.tmrVal = linkWr.data;
        OFF_CONFIG_KEY:      n.keyOk = (linkWr.data == KEY_OSC_UNLOCK);
        OFF_OSC_CONTROL: begin
          if (s.keyOk) begin
            n.osc = linkWr.data;
            calStart = linkWr.data[OSC_AUTO_CALIBRATION_MODE_LSB +: 2] == AUTO_CALIBRATION_MODE_PERIODIC &&
                       s.osc[OSC_AUTO_CALIBRATION_MODE_LSB +: 2] != AUTO_CALIBRATION_MODE_PERIODIC;
          end
          n.keyOk = 1'b0;
        end
        default: begin
          if (linkWr.addr > OFF_CAL_FRACTION &&
              linkWr.addr <= OFF_CAL_LAST) begin
            n.cal[linkWr.addr[2:0]] = linkWr.data;
          end
        end
      endcase
    end
    if (calStart) begin
      n.calSt = CAL_MEASURE;
      n.calSec = 10'h000;
      n.rcCount = 24'h00_0000;
      // restart the crystal second so the first window is a whole one
      n.xPresc = 15'h0000;
    end

    // reads: answer each new request toggle with the addressed byte
    n.rAck = s.rSync[1];
    if (s.rSync[1] != s.rAck) begin
      n.rdHold = regRead(linkRdAddr, s);
    end

    // pins
    case (s.square_wave_control[SQW_FREQ_LSB +: 5])
      5'h00:   wave = s.presc[0];
      default: begin
        if (s.square_wave_control[SQW_FREQ_LSB +: 5] <= SQW_FREQ_1HZ) begin
          wave = s.presc[s.square_wave_control[3:0] - 4'h1];
        end else begin
          wave = 1'b0;
        end
      end
    endcase
    wave = wave && s.square_wave_control[SQW_ENABLE];
    n.pins.waveToggle = wave;
    n.pins.squareWave = wave;
    n.pins.primaryIrq = (s.ctrl2[C2_PRIMARY_SEL_LSB +: 2] == 2'h1) ?
                        wave : s.ctrl1[C1_PRIMARY_LEVEL];
    n.pins.secondary = (s.ctrl2[C2_SECOND_SEL_LSB +: 3] == 3'h1) ?
                       wave : s.ctrl1[C1_SECONDARY_LEVEL];
    n.pins.resetReq = s.ctrl2[C2_EXT_RESET_EN] ?
                      s.extRstSync[1] : 1'b1;
    n.pins.timerIrq = !(s.tmrCtl[TMR_RUN] && s.tmrVal == 8'h00);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.ctrl1 <= RST_CONTROL_ONE;
      s.ctrl2 <= RST_CONTROL_TWO;
      s.imask <= RST_INTERRUPT_MASK;
      s.square_wave_control <= RST_SQUARE_WAVE;
      s.trimLo <= RST_RC_TRIM;
      s.trimHi <= RST_RC_TRIM;
      s.tmrCtl <= RST_COUNTDOWN_CTL;
      s.tmrVal <= RST_COUNTDOWN_VAL;
      s.osc <= RST_OSC_CONTROL;
      s.csSync <= 2'b11;
      s.calSt <= CAL_IDLE;
      s.pins <= PINS_RST;
    end else begin
      s <= n;
    end
  end

  assign primaryIrqPin   = s.pins.primaryIrq;
  assign secondaryPin    = s.pins.secondary;
  assign timerIrqPin     = s.pins.timerIrq;
  assign waveTogglePin   = s.pins.waveToggle;
  assign squareWavePin   = s.pins.squareWave;
  assign resetRequestPin = s.pins.resetReq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_primary_high;
    (s.ctrl1[C1_PRIMARY_LEVEL] && s.ctrl2[1:0] == 2'h0) |=> primaryIrqPin;
  endproperty
  a_primary_high: assert property (p_primary_high)
    else $error("primary pin not high");
  property p_secondary_high;
    (s.ctrl1[C1_SECONDARY_LEVEL] && s.ctrl2[4:2] == 3'h0) |=> secondaryPin;
  endproperty
  a_secondary_high: assert property (p_secondary_high)
    else $error("secondary pin not high");
  property p_reset_idle;
    !s.ctrl2[C2_EXT_RESET_EN] |=> resetRequestPin;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("reset request pin driven while disabled");
  property p_timer_idle;
    (!s.tmrCtl[TMR_RUN] && !(wrFire && linkWr.addr == OFF_COUNTDOWN_VALUE))
      |=> timerIrqPin && $stable(s.tmrVal);
  endproperty
  a_timer_idle: assert property (p_timer_idle)
    else $error("stopped timer moved or pulled its pin");
  property p_wave_quiet;
    (!s.square_wave_control[SQW_ENABLE] && $past(!s.square_wave_control[SQW_ENABLE])) |=>
      $stable(waveTogglePin) && !squareWavePin;
  endproperty
  a_wave_quiet: assert property (p_wave_quiet)
    else $error("wave pin toggled while disabled");
  property p_wave_1hz;
    (s.square_wave_control[SQW_ENABLE] && s.square_wave_control[4:0] == SQW_FREQ_1HZ) |=>
      squareWavePin == $past(s.presc[14]);
  endproperty
  a_wave_1hz: assert property (p_wave_1hz)
    else $error("1 Hz code does not follow the second divider");
  property p_osc_locked;
    (wrFire && linkWr.addr == OFF_OSC_CONTROL && !s.keyOk) |=>
      $stable(s.osc);
  endproperty
  a_osc_locked: assert property (p_osc_locked)
    else $error("oscillator control changed without key");
  property p_key_used;
    (wrFire && linkWr.addr == OFF_OSC_CONTROL) |=> !s.keyOk;
  endproperty
  a_key_used: assert property (p_key_used)
    else $error("key survived an oscillator control write");
  property p_cal_start;
    calStart |=> s.calSt == CAL_MEASURE ##1 s.calSec == 10'h000;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration did not start at once");
  property p_cal_deadline;
    s.calSt == CAL_MEASURE |-> s.calSec < 10'(CAL_DEADLINE_S);
  endproperty
  a_cal_deadline: assert property (p_cal_deadline)
    else $error("calibration ran past its deadline");
  property p_seconds_move;
    (secTick && !wrFire) |=> s.cal[1] != $past(s.cal[1]);
  endproperty
  a_seconds_move: assert property (p_seconds_move)
    else $error("seconds counter did not advance");
  property p_readback;
    (wrFire && linkWr.addr == OFF_CONTROL_ONE) |=>
      s.ctrl1 == $past(linkWr.data);
  endproperty
  a_readback: assert property (p_readback)
    else $error("control one does not hold written value");
  property p_no_power_write;
    !s.pwrSync[1] |-> !wrFire;
  endproperty
  a_no_power_write: assert property (p_no_power_write)
    else $error("write taken without main power");

  c_cal_store: cover property (s.calSt == CAL_MEASURE ##1
                               s.calSt == CAL_HOLD);
  c_osc_change: cover property (wrFire && linkWr.addr == OFF_OSC_CONTROL &&
                                s.keyOk);
  c_wave_on: cover property (s.square_wave_control[SQW_ENABLE] ##1 $rose(squareWavePin));
  c_second: cover property (secTick);
endmodule
`default_nettype wire

/* verilog/rtcs_pkg.sv */
`default_nettype none
package rtcs_pkg;
  // register offsets (7-bit serial address space)
  localparam logic [6:0] OFF_CAL_FRACTION    = 7'h00;
  localparam logic [6:0] OFF_CAL_LAST        = 7'h07;
  localparam logic [6:0] OFF_CONTROL_ONE     = 7'h10;
  localparam logic [6:0] OFF_CONTROL_TWO     = 7'h11;
  localparam logic [6:0] OFF_INTERRUPT_MASK  = 7'h12;
  localparam logic [6:0] OFF_SQUARE_WAVE     = 7'h13;
  localparam logic [6:0] OFF_RC_TRIM_LOW     = 7'h15;
  localparam logic [6:0] OFF_RC_TRIM_HIGH    = 7'h16;
  localparam logic [6:0] OFF_COUNTDOWN_CTL   = 7'h18;
  localparam logic [6:0] OFF_COUNTDOWN_VALUE = 7'h19;
  localparam logic [6:0] OFF_OSC_CONTROL     = 7'h1C;
  localparam logic [6:0] OFF_CONFIG_KEY      = 7'h1F;
  // field positions
  localparam int C1_PRIMARY_LEVEL   = 4;
  localparam int C1_SECONDARY_LEVEL = 5;
  localparam int C2_PRIMARY_SEL_LSB = 0;
  localparam int C2_SECOND_SEL_LSB  = 2;
  localparam int C2_EXT_RESET_EN    = 5;
  localparam int IM_ALARM_PULSE_LSB = 5;
  localparam int SQW_ENABLE         = 7;
  localparam int SQW_FREQ_LSB       = 0;
  localparam int TMR_RUN            = 7;
  localparam int TMR_FREQ_LSB       = 0;
  localparam int OSC_SOURCE         = 7;
  localparam int OSC_AUTO_CALIBRATION_MODE_LSB       = 5;
  // reset values
  localparam logic [7:0] RST_CONTROL_ONE    = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO    = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_MASK = 8'h00;
  localparam logic [7:0] RST_SQUARE_WAVE    = 8'h00;
  localparam logic [7:0] RST_RC_TRIM        = 8'h00;
  localparam logic [7:0] RST_COUNTDOWN_CTL  = 8'h00;
  localparam logic [7:0] RST_COUNTDOWN_VAL  = 8'h00;
  localparam logic [7:0] RST_OSC_CONTROL    = 8'h00;
  // codes and timing
  localparam logic [7:0] KEY_OSC_UNLOCK = 8'hA1;
  localparam logic [1:0] AUTO_CALIBRATION_MODE_PERIODIC  = 2'h3;
  localparam logic [4:0] SQW_FREQ_1HZ   = 5'h0F;
  localparam logic [7:0] RD_NOT_READY   = 8'hFF;
  localparam int XTAL_HZ        = 32768;
  localparam int CAL_PERIOD_S   = 512;
  localparam int CAL_DEADLINE_S = 60;

  typedef enum logic [1:0] {CAL_IDLE, CAL_MEASURE, CAL_HOLD} rtcs_cal_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } rtcs_xfer_t;

  typedef struct packed {
    logic primaryIrq;
    logic secondary;
    logic timerIrq;
    logic waveToggle;
    logic squareWave;
    logic resetReq;
  } rtcs_pins_t;
  localparam rtcs_pins_t PINS_RST = 6'b11_1001;

  typedef struct packed {
    logic [7:0]      ctrl1, ctrl2, imask, square_wave_control, trimLo, trimHi;
    logic [7:0]      tmrCtl, tmrVal, osc;
    logic            keyOk;
    logic [7:1][7:0] cal;
    logic [14:0]     presc, xPresc;
    logic [2:0]      xtalSync, wSync;
    logic [1:0]      extRstSync, pwrSync, csSync, rSync;
    logic            wSeen, rAck;
    logic [7:0]      rdHold;
    logic [15:0]     rcDiv;
    rtcs_cal_t       calSt;
    logic [9:0]      calSec;
    logic [23:0]     rcCount;
    rtcs_pins_t      pins;
  } rtcs_core_t;

  typedef struct packed {
    logic [2:0] bitCnt;
    logic [7:0] shift, sdoSh;
    logic       started, isWrite, wTog, rTog, sdoOe;
    logic [6:0] addr, rAddr;
    logic [1:0] ackSync;
    rtcs_xfer_t wHold;
  } rtcs_link_t;
endpackage
`default_nettype wire

/* dv/rtcs_spi_host.sv */
`timescale 1ns/1ns
`default_nettype none
// host end of the serial port; sck stands still outside frames
module rtcs_spi_host (
  // link pins driven by the host
  output var  logic sck,
  output var  logic csN,
  output var  logic sdi,
  // device answer
  input  wire logic sdo,
  input  wire logic sdoOe
);
  localparam int HALF = 24;
  logic lastSdo;
  logic misoLevel;

  // a released line shows the inverse of its last driven value
  always_comb misoLevel = sdoOe ? sdo : ~lastSdo;
  always @(sdo or sdoOe) begin
    if (sdoOe) lastSdo = sdo;
  end

  initial begin
    sck = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
    lastSdo = 1'b0;
  end

  // one frame: address byte then one data byte, or for a read the
  // dummy byte and one returned byte; sdi moves after falling edges
  task automatic frame(input logic wr, input logic [6:0] addr,
                       input logic [7:0] wdata,
                       output logic [7:0] rdata);
    logic [15:0] outBits;
    int          pulses;
    outBits = {wr, addr, wdata};
    pulses = wr ? 16 : 23;
    rdata = 8'h00;
    csN = 1'b0;
    #30;
    for (int i = 0; i < pulses; i++) begin
      sdi = outBits[15 - (i % 16)];
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
      if (i >= 15) rdata = {rdata[6:0], misoLevel};
    end
    // hold select past the last edge so the write is not lost
    #70 csN = 1'b1;
    #70;
  endtask

  // the oscillator register is only written after a key frame
  task automatic keyed_write(input logic [7:0] key, input logic [7:0] d);
    logic [7:0] q;
    frame(1'b1, 7'h1F, key, q);
    frame(1'b1, 7'h1C, d, q);
  endtask
endmodule
`default_nettype wire

/* dv/rtc_output_oscillator_config_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module rtc_output_oscillator_config_tb import rtcs_pkg::*;;
  logic       clk;
  logic       rst;
  logic       crystalInputPin;
  logic       mainPowerGood;
  logic       extResetInN;
  wire        sck;
  wire        csN;
  wire        sdi;
  logic       sdo;
  logic       sdoOe;
  logic [5:0] pinBus;
  int         mismatches;
  int         compares;
  int         n;
  logic [7:0] q;
  logic [7:0] fracA;
  logic [7:0] trimLo;
  logic [7:0] trimHi;

  rtcs_rtc #(.RC_DIV(4), .CAL_WINDOW_S(1)) dut_u (
    .clk(clk), .rst(rst), .sck(sck), .csN(csN), .sdi(sdi),
    .sdo(sdo), .sdoOe(sdoOe), .crystalInputPin(crystalInputPin),
    .mainPowerGood(mainPowerGood), .extResetInN(extResetInN),
    .primaryIrqPin(pinBus[5]), .secondaryPin(pinBus[4]),
    .timerIrqPin(pinBus[3]), .waveTogglePin(pinBus[2]),
    .squareWavePin(pinBus[1]), .resetRequestPin(pinBus[0])
  );

  rtcs_spi_host host_u (
    .sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // crystal edge every second core cycle keeps long counts short
  always @(negedge clk) crystalInputPin <= ~crystalInputPin;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.frame(1'b1, a, d, q);
  endtask

  task automatic expect_reg(input logic [6:0] a, input logic [7:0] e);
    host_u.frame(1'b0, a, 8'h00, q);
    check({8'h00, q}, {8'h00, e});
  endtask

  task automatic pins(input logic [5:0] e);
    @(negedge clk);
    check({10'h000, pinBus}, {10'h000, e});
  endtask

  // cycles between two toggles of the square-wave pin
  task automatic half_period(output int cnt);
    logic prev;
    int   guard;
    cnt = 0;
    guard = 0;
    @(negedge clk);
    prev = pinBus[1];
    while (pinBus[1] === prev && guard < 40000) begin
      @(negedge clk);
      guard++;
    end
    prev = pinBus[1];
    while (pinBus[1] === prev && cnt < 40000) begin
      @(negedge clk);
      cnt++;
    end
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #950_000;
    mismatches++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    mainPowerGood = 1'b1;
    extResetInN = 1'b0;
    crystalInputPin = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    pins(6'b00_1001);
    expect_reg(OFF_CONTROL_ONE, RST_CONTROL_ONE);
    expect_reg(OFF_CONTROL_TWO, RST_CONTROL_TWO);
    expect_reg(OFF_SQUARE_WAVE, RST_SQUARE_WAVE);
    expect_reg(OFF_OSC_CONTROL, RST_OSC_CONTROL);
    expect_reg(OFF_CONFIG_KEY, 8'h00);
    expect_reg(7'h7E, 8'h00);
    // reset input enabled passes the low request through
    wr(OFF_CONTROL_TWO, 8'h20);
    pins(6'b00_1000);
    wr(OFF_CONTROL_ONE, 8'h30);
    wr(OFF_CONTROL_TWO, 8'h00);
    pins(6'b11_1001);
    expect_reg(OFF_CONTROL_ONE, 8'h30);
    // select code 1 hands both pins to the stopped square wave
    wr(OFF_CONTROL_TWO, 8'h05);
    pins(6'b00_1001);
    wr(OFF_CONTROL_TWO, 8'h00);
    wr(OFF_INTERRUPT_MASK, 8'h60);
    expect_reg(OFF_INTERRUPT_MASK, 8'h60);
    wr(OFF_COUNTDOWN_VALUE, 8'h00);
    wr(OFF_COUNTDOWN_CTL, 8'h80);
    pins(6'b11_0001);
    // a running timer counts a loaded value down to zero
    wr(OFF_COUNTDOWN_VALUE, 8'h03);
    repeat (100) @(negedge clk);
    expect_reg(OFF_COUNTDOWN_VALUE, 8'h00);
    wr(OFF_COUNTDOWN_CTL, 8'h03);
    expect_reg(OFF_COUNTDOWN_CTL, 8'h03);
    pins(6'b11_1001);
    // a stopped timer keeps a loaded value
    wr(OFF_COUNTDOWN_VALUE, 8'h05);
    repeat (100) @(negedge clk);
    expect_reg(OFF_COUNTDOWN_VALUE, 8'h05);
    pins(6'b11_1001);
    wr(OFF_SQUARE_WAVE, 8'h01);
    repeat (4) begin
      repeat (9) @(negedge clk);
      pins(6'b11_1001);
    end
    wr(OFF_SQUARE_WAVE, 8'h81);
    half_period(n);
    check(16'(n), 16'd2);
    // oscillator control without the key stays put
    wr(OFF_OSC_CONTROL, 8'h80);
    expect_reg(OFF_OSC_CONTROL, 8'h00);
    host_u.keyed_write(KEY_OSC_UNLOCK, 8'h80);
    expect_reg(OFF_OSC_CONTROL, 8'h80);
    half_period(n);
    check(16'(n), 16'd4);
    wr(OFF_OSC_CONTROL, 8'h00);
    expect_reg(OFF_OSC_CONTROL, 8'h80);
    host_u.keyed_write(8'h5A, 8'h00);
    expect_reg(OFF_OSC_CONTROL, 8'h80);
    host_u.frame(1'b0, OFF_CAL_FRACTION, 8'h00, fracA);
    repeat (600) @(negedge clk);
    host_u.frame(1'b0, OFF_CAL_FRACTION, 8'h00, q);
    check({15'h0000, fracA !== q}, 16'h0001);
    // main supply lost: writes dropped, contents kept
    mainPowerGood = 1'b0;
    repeat (4) @(negedge clk);
    wr(OFF_INTERRUPT_MASK, 8'h00);
    expect_reg(OFF_INTERRUPT_MASK, 8'h60);
    mainPowerGood = 1'b1;
    repeat (4) @(negedge clk);
    host_u.keyed_write(KEY_OSC_UNLOCK, 8'h60);
    expect_reg(OFF_OSC_CONTROL, 8'h60);
    wr(OFF_SQUARE_WAVE, 8'h8F);
    half_period(n);
    check(16'(n), 16'd32768);
    trimHi = 8'h00;
    for (int k = 0; k < 40 && trimHi === 8'h00; k++) begin
      repeat (1000) @(negedge clk);
      host_u.frame(1'b0, OFF_RC_TRIM_HIGH, 8'h00, trimHi);
    end
    host_u.frame(1'b0, OFF_RC_TRIM_LOW, 8'h00, trimLo);
    // 32768 crystal edges against an RC tick every 4 cycles
    check({15'h0000, {trimHi, trimLo} >= 16'h3FFE &&
           {trimHi, trimLo} <= 16'h4002}, 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire
